// File: rdo_cfg.svh
// constants for the readout dot sequencer
`ifndef RDO_CFG_SVH
`define RDO_CFG_SVH
`define RDO_DOT_CNT_RST 5'h00
`define RDO_LOW_BITS 4
`define RDO_HPOS_RST 8'h00
`define RDO_VPOS_RST 7'h00
`define RDO_ROM_ADDR_RST 12'h000
`endif

// File: rdo_pkg.sv
// types for the readout dot sequencer
package rdo_pkg;
    typedef enum logic [2:0] {
        RDO_CHAR = 3'b000,
        RDO_VCUR1 = 3'b001,
        RDO_HCUR1 = 3'b010,
        RDO_VCUR0 = 3'b011,
        RDO_HCUR0 = 3'b100
    } rdo_mode_t;
    // deflection source selection
    typedef enum logic [1:0] {
        RDO_SRC_HDAC = 2'b00,
        RDO_SRC_VDAC = 2'b01,
        RDO_SRC_CUR0 = 2'b10,
        RDO_SRC_REF1 = 2'b11
    } rdo_src_t;
endpackage

// File: rdo_dot_seq.sv
// readout dot sequencer with display mode select
`include "rdo_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module rdo_dot_seq
    import rdo_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // pacing from dot cycle generator, asynchronous
    input wire logic dot_request,
    // character data and address
    input wire logic [7:0] char_code,
    input wire logic [7:0] char_addr,
    input wire logic [7:0] dot_data,
    // rom address and char counter step
    output logic [11:0] rom_addr,
    output logic char_advance,
    // dac words
    output logic [7:0] hdac_word,
    output logic [6:0] vdac_word,
    output logic vdac_line_sel,
    output logic vdac_center_offset,
    // deflection routing
    output logic [1:0] horiz_src,
    output logic [1:0] vert_src,
    output logic cursor_active
);

// ==========================================
// input synchronisers
logic [2:0] req_sync_q, req_sync_d;
logic req_rise;
logic req_fall;
logic end_of_char_n;
logic cursor_select;

// rom data and address bits share our clock, so they need no sync
// limitation: a request level shorter than one clock may be missed
assign end_of_char_n = dot_data[7];
assign cursor_select = char_addr[6];

always_comb begin
    req_sync_d = {req_sync_q[1:0], dot_request};
end

always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        req_sync_q <= 3'h0;
    end else begin
        req_sync_q <= req_sync_d;
    end
end

// edges are taken past the first stage only
assign req_rise = req_sync_q[1] & ~req_sync_q[2];
assign req_fall = ~req_sync_q[1] & req_sync_q[2];

// ==========================================
// end flag and character step
logic eoc_dly_q, eoc_dly_d;
logic char_adv_q, char_adv_d;

always_comb begin
    eoc_dly_d = eoc_dly_q;
    char_adv_d = 1'b0;

    if (req_rise) begin
        eoc_dly_d = end_of_char_n;
        char_adv_d = ~end_of_char_n;
    end
end

// the step pulse lasts one clock; the character counter outside
// must take it on that clock
// delayed flag resets high so the first character is not cleared
always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        eoc_dly_q <= 1'b1;
        char_adv_q <= 1'b0;
    end else begin
        eoc_dly_q <= eoc_dly_d;
        char_adv_q <= char_adv_d;
    end
end

assign char_advance = char_adv_q;

// ==========================================
// dot counter
// five bits: sixteen dots a block, two blocks at most
logic [4:0] dot_cnt_q, dot_cnt_d;
logic [11:0] rom_addr_q, rom_addr_d;
logic cnt_clr;

function automatic logic [11:0] rom_address(input logic [7:0] code,
                                            input logic [4:0] cnt);
    rom_address = {code[7:1], code[0] | cnt[4], cnt[3:0]};
endfunction

// the clear is a level: it holds the count at zero until the
// next character's first byte lifts the flag again
assign cnt_clr = ~end_of_char_n & ~eoc_dly_q;

always_comb begin
    dot_cnt_d = dot_cnt_q;
    if (cnt_clr) begin
        dot_cnt_d = `RDO_DOT_CNT_RST;
    end else if (req_fall) begin
        // low four bits roll into bit four
        dot_cnt_d = dot_cnt_q + 5'h01;
    end

    // address follows the next count so rom and counter move together
    rom_addr_d = rom_address(char_code, dot_cnt_d);
end

always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        dot_cnt_q <= `RDO_DOT_CNT_RST;
        rom_addr_q <= `RDO_ROM_ADDR_RST;
    end else begin
        dot_cnt_q <= dot_cnt_d;
        rom_addr_q <= rom_addr_d;
    end
end

assign rom_addr = rom_addr_q;

// ==========================================
// vertical latch
logic [6:0] vdac_q, vdac_d;
logic line_sel_q, line_sel_d;
logic ctr_off_q, ctr_off_d;

// line bits ride with the dot so a line change never tears a glyph
always_comb begin
    vdac_d = vdac_q;
    line_sel_d = line_sel_q;
    ctr_off_d = ctr_off_q;

    if (req_rise) begin
        vdac_d = {3'h0, dot_data[6:3]};
        line_sel_d = char_addr[5];
        ctr_off_d = char_addr[7];
    end
end

always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        vdac_q <= `RDO_VPOS_RST;
        line_sel_q <= 1'b0;
        ctr_off_q <= 1'b0;
    end else begin
        vdac_q <= vdac_d;
        line_sel_q <= line_sel_d;
        ctr_off_q <= ctr_off_d;
    end
end

assign vdac_word = vdac_q;
assign vdac_line_sel = line_sel_q;
assign vdac_center_offset = ctr_off_q;

// ==========================================
// horizontal latch
logic [7:0] hdac_q, hdac_d;
logic hdac_armed_q, hdac_armed_d;

// armed by the rise, so a lone fall after reset writes nothing
always_comb begin
    hdac_d = hdac_q;
    hdac_armed_d = hdac_armed_q | req_rise;

    // write held while request high, taken at its fall
    if (req_fall && hdac_armed_q) begin
        hdac_d = {char_addr[4:0], dot_data[2:0]};
        hdac_armed_d = req_rise;
    end
end

// taken on the falling clock, half a cycle after the detected fall,
// so the word is settled before the count steps
always_ff @(negedge clk or negedge nrst) begin
    if (!nrst) begin
        hdac_q <= `RDO_HPOS_RST;
        hdac_armed_q <= 1'b0;
    end else begin
        hdac_q <= hdac_d;
        hdac_armed_q <= hdac_armed_d;
    end
end

assign hdac_word = hdac_q;

// ==========================================
// mode select
rdo_mode_t mode_q, mode_d;
logic en_q, en_d;
logic [2:0] dd_q, dd_d;

// return code: bits five and four both low, bit three ignored
function automatic logic is_return(input logic [2:0] bits);
    is_return = (bits[2:1] == 2'b00);
endfunction

// cursor codes on bits five to three; any other code keeps the mode
function automatic rdo_mode_t cursor_mode(input logic [2:0] bits,
                                          input rdo_mode_t held);
    unique case (bits)
        3'b010: begin
            cursor_mode = RDO_VCUR1;
        end
        3'b011: begin
            cursor_mode = RDO_HCUR1;
        end
        3'b100: begin
            cursor_mode = RDO_VCUR0;
        end
        3'b101: begin
            cursor_mode = RDO_HCUR0;
        end

        default: begin
            cursor_mode = held;
        end
    endcase
endfunction

// dd bits are the ones latched at the previous request

always_comb begin
    en_d = en_q;
    dd_d = dd_q;
    if (req_rise) begin
        dd_d = dot_data[5:3];
        // mode held until return code seen
        en_d = (mode_q != RDO_CHAR) ? 1'b1 : cursor_select;
        if (mode_q != RDO_CHAR && is_return(dd_q)) begin
            en_d = cursor_select;
        end
    end

    mode_d = mode_q;
    if (!en_q) begin
        mode_d = RDO_CHAR;
    end else begin
        mode_d = cursor_mode(dd_q, mode_q);
    end
end

// ==========================================
// deflection routing
logic [1:0] hsrc_q, hsrc_d;
logic [1:0] vsrc_q, vsrc_d;

// vertical cursors keep the dac on horizontal; horizontal ones swap
always_comb begin
    // orientation alternates per segment code; reference level changes every two codes
    unique case (mode_q)
        RDO_CHAR: begin
            hsrc_d = RDO_SRC_HDAC;
            vsrc_d = RDO_SRC_VDAC;
        end

        RDO_VCUR1: begin
            hsrc_d = RDO_SRC_HDAC;
            vsrc_d = RDO_SRC_REF1;
        end

        RDO_HCUR1: begin
            hsrc_d = RDO_SRC_REF1;
            vsrc_d = RDO_SRC_HDAC;
        end

        RDO_VCUR0: begin
            hsrc_d = RDO_SRC_HDAC;
            vsrc_d = RDO_SRC_CUR0;
        end

        RDO_HCUR0: begin
            hsrc_d = RDO_SRC_CUR0;
            vsrc_d = RDO_SRC_HDAC;
        end

        default: begin
            hsrc_d = RDO_SRC_HDAC;
            vsrc_d = RDO_SRC_VDAC;
        end
    endcase
end

always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        en_q <= 1'b0;
        dd_q <= 3'h0;
        mode_q <= RDO_CHAR;
    end else begin
        en_q <= en_d;
        dd_q <= dd_d;
        mode_q <= mode_d;
    end
end

// routing registered so the switches move on a clean edge
always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        hsrc_q <= RDO_SRC_HDAC;
        vsrc_q <= RDO_SRC_VDAC;
    end else begin
        hsrc_q <= hsrc_d;
        vsrc_q <= vsrc_d;
    end
end

assign horiz_src = hsrc_q;
assign vert_src = vsrc_q;
assign cursor_active = en_q;

endmodule
`default_nettype wire

// File: rdo_dot_seq_asserts.sv
// port-level assertions for the readout dot sequencer
`timescale 1ns/10ps
`default_nettype none
module rdo_dot_seq_asserts
    import rdo_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // inputs
    input wire logic dot_request,
    input wire logic [7:0] char_code,
    input wire logic [7:0] char_addr,
    input wire logic [7:0] dot_data,
    // outputs
    input wire logic [11:0] rom_addr,
    input wire logic char_advance,
    input wire logic [7:0] hdac_word,
    input wire logic [6:0] vdac_word,
    input wire logic vdac_line_sel,
    input wire logic vdac_center_offset,
    input wire logic [1:0] horiz_src,
    input wire logic [1:0] vert_src,
    input wire logic cursor_active
);
    // ==========================================
    // checks, windows allow for the two-flop sync
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_vdac_capture:
    assert property ($rose(dot_request) |-> ##[1:4]
        vdac_word == {3'h0, dot_data[6:3]}) else $error("vdac word");
    a_line_bits:
    assert property ($rose(dot_request) |-> ##[1:4]
        vdac_line_sel == char_addr[5] && vdac_center_offset == char_addr[7])
        else $error("line select");
    a_rom_upper:
    assert property ($fell(dot_request) |-> ##[1:4]
        rom_addr[11:5] == char_code[7:1] && (rom_addr[4] || !char_code[0]))
        else $error("rom address");
    a_hdac_word:
    assert property ($fell(dot_request) |-> ##2
        hdac_word == {char_addr[4:0], dot_data[2:0]}) else $error("hdac word");
    a_hdac_when:
    assert property ($changed(hdac_word) |-> !dot_request)
        else $error("hdac moved");
    a_vdac_when:
    assert property ($changed(vdac_word) |-> dot_request)
        else $error("vdac moved");
    a_adv_pulse:
    assert property (char_advance |=> !char_advance) else $error("advance");
    a_adv_cause:
    assert property (char_advance |-> dot_request && $past(dot_request, 2))
        else $error("advance cause");
    a_src_legal:
    assert property (horiz_src != RDO_SRC_VDAC &&
        (vert_src != RDO_SRC_VDAC || horiz_src == RDO_SRC_HDAC))
        else $error("routing");
    c_advance: cover property (char_advance);
    c_cursor: cover property ($rose(cursor_active));
    c_block: cover property (rom_addr[4] && !char_code[0]);
endmodule
bind rdo_dot_seq rdo_dot_seq_asserts u_chk (.clk, .nrst, .dot_request,
    .char_code, .char_addr, .dot_data, .rom_addr, .char_advance, .hdac_word,
    .vdac_word, .vdac_line_sel, .vdac_center_offset, .horiz_src, .vert_src,
    .cursor_active);
`default_nettype wire

// File: rdo_rom_model.sv
// character rom model: dot bytes derived from the address
`timescale 1ns/10ps
`default_nettype none
module rdo_rom_model (
    // rom address in, dot byte out
    input wire logic [11:0] rom_addr,
    output logic [7:0] dot_data
);
    // ==========================================
    // last index is code bits six to two; the flag stays low past it
    // so the delayed copy still sees it on the following request
    always_comb begin
        dot_data[7] = rom_addr[4:0] < rom_addr[10:6];
        dot_data[6:3] = {rom_addr[0], rom_addr[7:5]};
        dot_data[2:0] = rom_addr[3:1];
    end
endmodule
`default_nettype wire

// File: testbench.sv
// self-checking bench for the readout dot sequencer
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import rdo_pkg::*;
    logic clk, nrst, dot_request, char_advance, vdac_line_sel;
    logic vdac_center_offset, cursor_active;
    logic [7:0] char_code, char_addr, dot_data, hdac_word;
    logic [11:0] rom_addr;
    logic [6:0] vdac_word;
    logic [1:0] horiz_src, vert_src;
    logic [15:0] lfsr = 16'h91f2;
    logic [7:0] codes [4] = '{8'h10, 8'h00, 8'h44, 8'h11};
    logic [7:0] cc [6] = '{8'h04, 8'h06, 8'h08, 8'h0a, 8'h00, 8'h00};
    logic [5:0] ce [6] = '{6'h33, 6'h3c, 6'h32, 6'h38, 6'h00, 6'h21};
    logic [5:0] csel = 6'b001101;
    int failures = 0, tests_run = 0, rises = 0;
    int exp_q [$];
    rdo_dot_seq i_dut (.clk, .nrst, .dot_request, .char_code, .char_addr,
        .dot_data, .rom_addr, .char_advance, .hdac_word, .vdac_word,
        .vdac_line_sel, .vdac_center_offset, .horiz_src, .vert_src,
        .cursor_active);
    rdo_rom_model i_rom (.rom_addr, .dot_data);
    // ==========================================
    // helpers
    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic cmp(input string what, input logic [11:0] s, e);
        tests_run++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic do_reset;
        nrst = 0;
        repeat (12) @(negedge clk);
        nrst = 1;
        repeat (3) @(negedge clk);
    endtask
    // request held well past the sync delay in both phases
    // dot byte noted before each edge: the count moves after it
    task automatic dot(input logic [7:0] code, addr);
        logic [7:0] d;
        char_code = code;
        char_addr = addr;
        repeat (4) @(negedge clk);
        d = dot_data;
        dot_request = 1;
        repeat (6) @(negedge clk);
        cmp("vdac", {3'h0, vdac_line_sel, vdac_center_offset, vdac_word},
            {3'h0, addr[5], addr[7], 3'h0, d[6:3]});
        d = dot_data;
        dot_request = 0;
        repeat (6) @(negedge clk);
        cmp("hdac", {4'h0, hdac_word},
            {4'h0, addr[4:0], d[2:0]});
    endtask
    // ==========================================
    // clock, monitor, watchdog
    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    always @(posedge dot_request) rises++;
    always @(negedge clk) begin
        if (!nrst)
            rises = 0;
        else if (char_advance === 1'b1 && exp_q.size() > 0)
            cmp("dots", 12'(rises), 12'(exp_q.pop_front()));
    end
    initial begin
        #100000;
        failures++;
        end_sim;
    end
    // ==========================================
    // main sequence
    initial begin
        logic [7:0] a, c;
        logic [4:0] ib;
        int n;
        nrst = 0;
        dot_request = 0;
        char_code = 8'h00;
        char_addr = 8'h00;
        foreach (codes[k]) begin
            do_reset;
            cmp("reset", {6'h0, char_advance, cursor_active, horiz_src,
                vert_src}, 12'h001);
            lfsr = nxt(lfsr);
            a = lfsr[7:0] & 8'hbf;
            c = codes[k];
            n = c[0] ? 0 : c[6:2];
            exp_q.push_back(n + 1);
            for (int i = 0; i <= n; i++) begin
                dot(c, a);
                ib = 5'(i + 1);
                if (i < n)
                    cmp("rom", rom_addr, {c[7:1], c[0] | ib[4],
                        ib[3:0]});
            end
        end
        cmp("pending", 12'(exp_q.size()), 12'h000);
        $display("char test done");
        do_reset;
        for (int k = 0; k < 6; k++) begin
            lfsr = nxt(lfsr);
            dot(cc[k], {lfsr[7], csel[k], lfsr[5:0]});
            if (ce[k][5])
                cmp("mode", {7'h0, cursor_active, horiz_src, vert_src},
                    {7'h0, ce[k][4:0]});
        end
        $display("cursor test done");
        end_sim;
    end
endmodule
`default_nettype wire
